// ### platform_power_params.svh
// Timing counts and reset values for the platform power signal control block.
`ifndef PLATFORM_POWER_PARAMS_SVH
`define PLATFORM_POWER_PARAMS_SVH

// System clock rate in MHz (period 25 ns).
`define PPSC_CLK_MHZ 40

// Least time the platform reset is held on a cold, warm or global reset, in ns.
`define PPSC_RESET_HOLD_NS 1000
// Least hold in clock cycles, rounded up.
`define PPSC_RESET_HOLD_CYCLES ((`PPSC_RESET_HOLD_NS * `PPSC_CLK_MHZ + 999) / 1000)

// Least time the PHY power-control request stands after a wake, in ns.
`define PPSC_PHY_PULSE_NS 10000
// Least pulse length in clock cycles, rounded up.
`define PPSC_PHY_PULSE_CYCLES ((`PPSC_PHY_PULSE_NS * `PPSC_CLK_MHZ + 999) / 1000)

// Synchroniser reset values: power good and mains low, active-low inputs high.
`define PPSC_PG_RESET_VAL 1'b0
`define PPSC_BATTERY_LOW_N_RESET_VAL 1'b1
`define PPSC_MAINS_RESET_VAL 1'b0
`define PPSC_WAKE_RESET_VAL 1'b1

`endif

// ### platform_power_pkg.sv
// Types shared by the platform power signal control block.
package platform_power_pkg;

  // Power state of the controller.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_RESET,
    ST_RUN,
    ST_SLEEP,
    ST_DEEP
  } pwr_state_t;

  // Requested sleep state; the fourth code is illegal.
  typedef enum logic [1:0] {
    SLP_S3,
    SLP_S4,
    SLP_S5
  } sleep_kind_t;

endpackage

// ### pin_sync3.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Pin and its synchronised level.
  input wire logic pin_i,
  output logic level_o
);

  logic ff1_q;
  logic ff2_q;
  logic ff3_q;
  logic level_q;
  logic agree;

  // Only the second stage reads the first; the filter looks at stages two and three.
  assign agree = (ff2_q == ff3_q);

  // Stages and filtered level; a change counts once stages two and three agree.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ff1_q <= RESET_VAL;
      ff2_q <= RESET_VAL;
      ff3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      ff1_q <= pin_i;
      ff2_q <= ff1_q;
      ff3_q <= ff2_q;
      if (agree) begin
        level_q <= ff3_q;
      end
    end
  end

  assign level_o = level_q;

  // The level only moves to a value that stages two and three held together.
  property p_sync_agree;
    @(posedge clk_sys_i) disable iff (!arst_n_i)
      (level_q != $past(level_q)) |-> ($past(ff2_q) == level_q && $past(ff3_q) == level_q);
  endproperty
  a_sync_agree: assert property (p_sync_agree) else $error("sync level moved without agreement");

endmodule // pin_sync3

`default_nettype wire

// ### platform_power_signal_control.sv
// Sideband power signal control: resets, idle-rail gate, PHY power and battery-low handling.
//
// What this block does
// - Power good low forces platform reset asserted.
// - Power good treated as fully asynchronous input.
// - Battery low blocks wake and deep-sleep exit.
// - Enabled battery-low assertion raises management interrupt.
// - Mains input and policy choose deep-sleep entry.
// - Deep sleep only from S4 or S5.
// - Idle-rail gate asserted low during C10.
// - Memory reset is active-low open-drain output.
// - Low network wake input requests a wake.
// - PHY power-control output requests PHY power restore.
// - Platform reset low in sleep and resets.
`timescale 1ns/1ps
`default_nettype none
`include "platform_power_params.svh"

module platform_power_signal_control #(
  parameter int RESET_HOLD_CYCLES = `PPSC_RESET_HOLD_CYCLES,
  parameter int PHY_PULSE_CYCLES = `PPSC_PHY_PULSE_CYCLES,
  parameter int CNT_W = 16
) (
  // Clock and reset.
  input wire logic clk_sys_i,
  input wire logic arst_n_i,
  // Asynchronous platform pins.
  input wire logic core_power_good_i,
  input wire logic battery_low_n_i,
  input wire logic mains_present_i,
  input wire logic network_wake_n_i,
  // Requests from the rest of the power controller, same clock.
  input wire logic sleep_enter_i,
  input wire logic [1:0] sleep_kind_i,
  input wire logic wake_req_i,
  input wire logic reset_req_i,
  input wire logic cpu_c10_i,
  // Configuration levels.
  input wire logic deep_sleep_en_i,
  input wire logic deep_sleep_batt_only_i,
  input wire logic smi_battery_low_en_i,
  input wire logic smi_ack_i,
  // Platform outputs.
  output logic platform_reset_n_o,
  output logic mem_reset_n_o,
  output logic mem_reset_oe_o,
  output logic idle_rail_gate_n_o,
  output logic network_phy_power_ctl_o,
  output logic sys_mgmt_interrupt_n_o,
  // State indications.
  output logic in_sleep_o,
  output logic in_deep_sleep_o
);

  // Refuse counts that the counters cannot hold or that would be zero.
  if (RESET_HOLD_CYCLES < 1 || RESET_HOLD_CYCLES >= (1 << CNT_W)) begin : g_chk_rst
    $error("RESET_HOLD_CYCLES out of range for CNT_W");
  end
  if (PHY_PULSE_CYCLES < 1 || PHY_PULSE_CYCLES >= (1 << CNT_W)) begin : g_chk_phy
    $error("PHY_PULSE_CYCLES out of range for CNT_W");
  end

  localparam logic [CNT_W-1:0] RST_LOAD = CNT_W'(RESET_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] PHY_LOAD = CNT_W'(PHY_PULSE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

  platform_power_pkg::pwr_state_t state_q;
  platform_power_pkg::pwr_state_t state_d;
  platform_power_pkg::sleep_kind_t kind_q;
  platform_power_pkg::sleep_kind_t kind_d;
  logic pg_s;
  logic battery_low_n_n_s;
  logic mains_s;
  logic wake_n_s;
  logic battery_low_n_n_prev_q;
  logic [CNT_W-1:0] rst_cnt_q;
  logic [CNT_W-1:0] rst_cnt_d;
  logic [CNT_W-1:0] phy_cnt_q;
  logic [CNT_W-1:0] phy_cnt_d;
  logic plat_rst_n_q;
  logic mem_oe_q;
  logic mem_oe_d;
  logic gate_n_q;
  logic phy_pc_q;
  logic smi_q;
  logic wake_ok;
  logic deep_ok;
  logic enter_reset;
  logic sleep_exit;
  logic battery_low_n_event;

  // Each asynchronous pin gets its own synchroniser before any state logic.
  pin_sync3 #(.RESET_VAL(`PPSC_PG_RESET_VAL)) u_sync_pg (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(core_power_good_i),
    .level_o(pg_s)
  );
  pin_sync3 #(.RESET_VAL(`PPSC_BATTERY_LOW_N_RESET_VAL)) u_sync_battery_low_n (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(battery_low_n_i),
    .level_o(battery_low_n_n_s)
  );
  pin_sync3 #(.RESET_VAL(`PPSC_MAINS_RESET_VAL)) u_sync_mains (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(mains_present_i),
    .level_o(mains_s)
  );
  pin_sync3 #(.RESET_VAL(`PPSC_WAKE_RESET_VAL)) u_sync_wake (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .pin_i(network_wake_n_i),
    .level_o(wake_n_s)
  );

  // Wake and deep-sleep qualifiers.
  // A wake is a software request or a low network wake level, refused under battery low.
  assign wake_ok = (wake_req_i | ~wake_n_s) & battery_low_n_n_s;
  // Deep sleep never follows S3; the policy may limit it to battery operation.
  assign deep_ok = deep_sleep_en_i
                 & (kind_q != platform_power_pkg::SLP_S3)
                 & (~deep_sleep_batt_only_i | ~mains_s);
  assign battery_low_n_event = battery_low_n_n_prev_q & ~battery_low_n_n_s;

  // Next power state; loss of power good overrides everything.
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      platform_power_pkg::ST_OFF: begin
        // Power good is trusted as soon as the synchroniser passes it; no settling time is counted here.
        if (pg_s) begin
          state_d = platform_power_pkg::ST_RESET;
        end
      end
      platform_power_pkg::ST_RESET: begin
        if (rst_cnt_q == CNT_ZERO) begin
          state_d = platform_power_pkg::ST_RUN;
        end
      end
      platform_power_pkg::ST_RUN: begin
        if (reset_req_i) begin
          state_d = platform_power_pkg::ST_RESET;
        end else if (sleep_enter_i) begin
          state_d = platform_power_pkg::ST_SLEEP;
        end
      end
      platform_power_pkg::ST_SLEEP: begin
        if (wake_ok) begin
          state_d = platform_power_pkg::ST_RESET;
        end else if (deep_ok) begin
          state_d = platform_power_pkg::ST_DEEP;
        end
      end
      platform_power_pkg::ST_DEEP: begin
        if (wake_ok) begin
          state_d = platform_power_pkg::ST_RESET;
        end
      end
      default: begin
        state_d = platform_power_pkg::ST_OFF;
      end
    endcase
    if (!pg_s) begin
      state_d = platform_power_pkg::ST_OFF;
    end
  end

  // Latch the sleep kind on entry; the illegal code is taken as S5.
  always_comb begin
    kind_d = kind_q;
    if (state_q == platform_power_pkg::ST_RUN && state_d == platform_power_pkg::ST_SLEEP) begin
      unique case (sleep_kind_i)
        2'h0: kind_d = platform_power_pkg::SLP_S3;
        2'h1: kind_d = platform_power_pkg::SLP_S4;
        default: kind_d = platform_power_pkg::SLP_S5;
      endcase
    end
  end

  // Reset hold and PHY pulse counters.
  assign enter_reset = (state_d == platform_power_pkg::ST_RESET)
                     && (state_q != platform_power_pkg::ST_RESET);
  assign sleep_exit = enter_reset && ((state_q == platform_power_pkg::ST_SLEEP)
                                   || (state_q == platform_power_pkg::ST_DEEP));
  assign rst_cnt_d = enter_reset ? RST_LOAD :
                     (rst_cnt_q != CNT_ZERO) ? (rst_cnt_q - CNT_ONE) : CNT_ZERO;
  // Power restore is asked for on each wake out of sleep or deep sleep; it drops if power good falls.
  assign phy_cnt_d = !pg_s ? CNT_ZERO :
                     sleep_exit ? PHY_LOAD :
                     (phy_cnt_q != CNT_ZERO) ? (phy_cnt_q - CNT_ONE) : CNT_ZERO;

  // DRAM reset is driven in power-off and resets, but released in S3 to keep self-refresh.
  always_comb begin
    mem_oe_d = 1'b1;
    unique case (state_d)
      platform_power_pkg::ST_RUN: mem_oe_d = 1'b0;
      platform_power_pkg::ST_SLEEP: mem_oe_d = (kind_d != platform_power_pkg::SLP_S3);
      default: mem_oe_d = 1'b1;
    endcase
  end

  // State and sleep kind.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= platform_power_pkg::ST_OFF;
      kind_q <= platform_power_pkg::SLP_S3;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
    end
  end

  // Counters.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_cnt_q <= CNT_ZERO;
      phy_cnt_q <= CNT_ZERO;
    end else begin
      rst_cnt_q <= rst_cnt_d;
      phy_cnt_q <= phy_cnt_d;
    end
  end

  // Output flip-flops, all taken from the next state so they track the state register.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      plat_rst_n_q <= 1'b0;
      mem_oe_q <= 1'b1;
      gate_n_q <= 1'b1;
      phy_pc_q <= 1'b0;
    end else begin
      plat_rst_n_q <= (state_d == platform_power_pkg::ST_RUN);
      mem_oe_q <= mem_oe_d;
      // Board logic must keep the gated rails' power goods high while this is low.
      gate_n_q <= ~((state_d == platform_power_pkg::ST_RUN) & cpu_c10_i);
      phy_pc_q <= (phy_cnt_d != CNT_ZERO);
    end
  end

  // Battery-low interrupt flag; a new event in the acknowledge cycle wins.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      battery_low_n_n_prev_q <= 1'b1;
      smi_q <= 1'b0;
    end else begin
      battery_low_n_n_prev_q <= battery_low_n_n_s;
      if (battery_low_n_event && smi_battery_low_en_i) begin
        smi_q <= 1'b1;
      end else if (smi_ack_i) begin
        smi_q <= 1'b0;
      end
    end
  end

  // Pins. The memory reset is open-drain: it only ever pulls low.
  assign platform_reset_n_o = plat_rst_n_q;
  assign mem_reset_n_o = 1'b0;
  assign mem_reset_oe_o = mem_oe_q;
  assign idle_rail_gate_n_o = gate_n_q;
  assign network_phy_power_ctl_o = phy_pc_q;
  assign sys_mgmt_interrupt_n_o = ~smi_q;
  assign in_sleep_o = (state_q == platform_power_pkg::ST_SLEEP);
  assign in_deep_sleep_o = (state_q == platform_power_pkg::ST_DEEP);

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_leave_sleep;
    (in_sleep_o || in_deep_sleep_o) && pg_s && wake_ok;
  endsequence
  sequence s_enter_sleep;
    (state_q == platform_power_pkg::ST_RUN) && pg_s && !reset_req_i && sleep_enter_i;
  endsequence

  property p_pg_low_reset;
    !pg_s |=> !platform_reset_n_o && state_q == platform_power_pkg::ST_OFF;
  endproperty
  a_pg_low_reset: assert property (p_pg_low_reset) else $error("reset not asserted");

  property p_pin_to_reset;
    (!core_power_good_i [*6]) |-> !platform_reset_n_o;
  endproperty
  a_pin_to_reset: assert property (p_pin_to_reset) else $error("pin loss not seen");

  property p_battery_low_n_blocks;
    (in_sleep_o || in_deep_sleep_o) && !battery_low_n_n_s |=> state_q != platform_power_pkg::ST_RESET;
  endproperty
  a_battery_low_n_blocks: assert property (p_battery_low_n_blocks) else $error("woke on battery low");

  property p_smi_raise;
    battery_low_n_event && smi_battery_low_en_i |=> !sys_mgmt_interrupt_n_o
      ##1 (!sys_mgmt_interrupt_n_o || $past(smi_ack_i));
  endproperty
  a_smi_raise: assert property (p_smi_raise) else $error("interrupt not raised");

  property p_deep_policy;
    in_deep_sleep_o && !$past(in_deep_sleep_o)
      |-> $past(deep_sleep_en_i) && !($past(deep_sleep_batt_only_i) && $past(mains_s));
  endproperty
  a_deep_policy: assert property (p_deep_policy) else $error("deep sleep against policy");

  property p_no_deep_s3;
    in_deep_sleep_o |-> kind_q != platform_power_pkg::SLP_S3;
  endproperty
  a_no_deep_s3: assert property (p_no_deep_s3) else $error("deep sleep from S3");

  property p_c10_gate;
    (state_d == platform_power_pkg::ST_RUN) && cpu_c10_i |=> !idle_rail_gate_n_o;
  endproperty
  a_c10_gate: assert property (p_c10_gate) else $error("gate not asserted in C10");

  property p_mem_reset_off;
    !pg_s |=> mem_reset_oe_o && !mem_reset_n_o;
  endproperty
  a_mem_reset_off: assert property (p_mem_reset_off) else $error("DRAM reset not driven");

  property p_net_wake;
    in_sleep_o && pg_s && !wake_n_s && battery_low_n_n_s |=> state_q == platform_power_pkg::ST_RESET;
  endproperty
  a_net_wake: assert property (p_net_wake) else $error("network wake ignored");

  property p_phy_pulse;
    s_leave_sleep ##1 pg_s [*8] |-> network_phy_power_ctl_o;
  endproperty
  a_phy_pulse: assert property (p_phy_pulse) else $error("PHY power request missing");

  property p_sleep_reset;
    s_enter_sleep |=> !platform_reset_n_o && in_sleep_o;
  endproperty
  a_sleep_reset: assert property (p_sleep_reset) else $error("reset released in sleep");

endmodule // platform_power_signal_control

`default_nettype wire

// ### board_model.sv
// Behavioural model of the board around the power signal block.
`timescale 1ns/1ps
`default_nettype none

module board_model #(
  // Rail settling time before power good, 5 ms; the bench shortens it to keep runs brief.
  parameter int RAIL_STABLE_NS = 32'h004C_4B40
) (
  // Commands from the bench.
  input wire logic rails_on_i,
  input wire logic batt_ok_i,
  input wire logic on_mains_i,
  input wire logic wake_i,
  // Levels driven by the block.
  input wire logic mem_reset_n_i,
  input wire logic mem_reset_oe_i,
  input wire logic idle_rail_gate_n_i,
  // Board pins toward the block.
  output logic core_power_good_o,
  output logic battery_low_n_o,
  output logic mains_present_o,
  output logic network_wake_n_o,
  output logic dram_reset_n_o,
  output logic gated_rails_pg_o
);
  // Power good rises only after the rails have settled, at a time unrelated to the clock.
  // One process owns the pin, so it is low from time zero and never unknown.
  initial begin
    core_power_good_o = 1'b0;
    forever begin
      @(rails_on_i);
      if (!rails_on_i) begin
        core_power_good_o = 1'b0;
      end else begin
        #(RAIL_STABLE_NS);
        if (rails_on_i) core_power_good_o = 1'b1;
      end
    end
  end

  // Pins move off the clock grid on purpose, so the synchronisers see true async edges.
  assign #3 battery_low_n_o = batt_ok_i;
  assign #7 mains_present_o = on_mains_i;
  assign #5 network_wake_n_o = wake_i ? 1'b0 : 1'b1;

  // Open-drain lines fall back to their pull-up when nobody pulls them low.
  assign dram_reset_n_o = mem_reset_oe_i ? mem_reset_n_i : 1'b1;
  assign gated_rails_pg_o = rails_on_i | !idle_rail_gate_n_i;
endmodule // board_model

`default_nettype wire

// ### tb.sv
// Self-checking testbench for the platform power signal control block.
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int K_RST = 0, K_ST = 1, K_PHY = 2, K_SMI = 3, K_GATE = 4;
  logic clk_sys_i = 1'b0;
  logic arst_n_i;
  logic rails_on, batt_ok, on_mains, wake_pin;
  logic sleep_enter, wake_req, reset_req, cpu_c10;
  logic [1:0] sleep_kind;
  logic deep_en, batt_only, smi_en, smi_ack;
  wire core_pg, battery_low_n_n, mains, wake_n, dram_n, rails_pg;
  wire plat_n, mem_n, mem_oe, gate_n, phy, smi_n, slp, deep;
  logic [1:0] q[5][$];
  logic [1:0] cur[5];
  logic [1:0] prv[5];
  logic mon_on = 1'b0;
  int miscompares = 0, tests_run = 0, cyc = 0;
  logic [31:0] lfsr_q = 32'h0000_2799;

  always #12.5 clk_sys_i = ~clk_sys_i;

  board_model #(.RAIL_STABLE_NS(500)) board (.rails_on_i(rails_on), .batt_ok_i(batt_ok),
    .on_mains_i(on_mains), .wake_i(wake_pin), .mem_reset_n_i(mem_n), .mem_reset_oe_i(mem_oe),
    .idle_rail_gate_n_i(gate_n), .core_power_good_o(core_pg), .battery_low_n_o(battery_low_n_n),
    .mains_present_o(mains), .network_wake_n_o(wake_n), .dram_reset_n_o(dram_n),
    .gated_rails_pg_o(rails_pg));

  // Short hold and pulse counts keep the run brief; expectations do not depend on them.
  platform_power_signal_control #(.RESET_HOLD_CYCLES(2), .PHY_PULSE_CYCLES(10), .CNT_W(16)) uut (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .core_power_good_i(core_pg),
    .battery_low_n_i(battery_low_n_n), .mains_present_i(mains), .network_wake_n_i(wake_n),
    .sleep_enter_i(sleep_enter), .sleep_kind_i(sleep_kind), .wake_req_i(wake_req),
    .reset_req_i(reset_req), .cpu_c10_i(cpu_c10), .deep_sleep_en_i(deep_en),
    .deep_sleep_batt_only_i(batt_only), .smi_battery_low_en_i(smi_en), .smi_ack_i(smi_ack),
    .platform_reset_n_o(plat_n), .mem_reset_n_o(mem_n), .mem_reset_oe_o(mem_oe),
    .idle_rail_gate_n_o(gate_n), .network_phy_power_ctl_o(phy), .sys_mgmt_interrupt_n_o(smi_n),
    .in_sleep_o(slp), .in_deep_sleep_o(deep));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Inputs always move 2 ns after the rising edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #2;
  endtask

  task automatic chk(input logic [1:0] exp, input logic [1:0] act);
    tests_run++;
    if (act !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %b want %b", $time, act, exp);
    end
  endtask

  // A change with no note waiting is as wrong as a wrong value.
  task automatic cmp(input int k);
    if (q[k].size() == 0) begin
      miscompares++;
      $display("[FAIL] %0t unexpected change of kind %0d", $time, k);
    end else begin
      chk(q[k].pop_front(), cur[k]);
    end
  endtask

  task automatic give_verdict();
    if (miscompares == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic sleep_go(input logic [1:0] k);
    sleep_kind = k;
    sleep_enter = 1'b1;
    tick(1);
    sleep_enter = 1'b0;
  endtask

  // A wake leaves sleep, raises the PHY request, releases the platform reset, then drops the PHY request.
  task automatic expect_wake();
    q[K_ST].push_back(2'h0);
    q[K_PHY].push_back(2'h1);
    q[K_PHY].push_back(2'h0);
    q[K_RST].push_back(2'h3);
  endtask

  // Monitor: samples settled outputs each cycle and checks every change against the notes.
  always @(posedge clk_sys_i) begin
    #1;
    cur[K_RST] = {plat_n, dram_n};
    cur[K_ST] = {slp, deep};
    cur[K_PHY] = {1'b0, phy};
    cur[K_SMI] = {1'b0, smi_n};
    cur[K_GATE] = {1'b0, gate_n};
    if (mon_on) begin
      if (cur[K_RST] !== prv[K_RST]) cmp(K_RST);
      if (cur[K_ST] !== prv[K_ST]) cmp(K_ST);
      if (cur[K_PHY] !== prv[K_PHY]) cmp(K_PHY);
      if (cur[K_SMI] !== prv[K_SMI]) cmp(K_SMI);
      if (cur[K_GATE] !== prv[K_GATE]) cmp(K_GATE);
      if (!gate_n) chk(2'h1, {1'b0, rails_pg});
    end
    prv = cur;
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      give_verdict();
    end
  end

  initial begin
    arst_n_i = 1'b0;
    {rails_on, batt_ok, on_mains, wake_pin} = 4'h6;
    {sleep_enter, wake_req, reset_req, cpu_c10} = 4'h0;
    {deep_en, batt_only, smi_en, smi_ack} = 4'h0;
    sleep_kind = 2'h0;
    tick(3);
    chk(2'h1, {plat_n, mem_oe});
    chk(2'h3, {gate_n, smi_n});
    chk(2'h0, {phy, mem_n});
    arst_n_i = 1'b1;
    mon_on = 1'b1;
    q[K_RST].push_back(2'h3);
    rails_on = 1'b1;
    tick(40);
    q[K_GATE].push_back(2'h0);
    q[K_GATE].push_back(2'h1);
    cpu_c10 = 1'b1;
    tick(6);
    cpu_c10 = 1'b0;
    tick(6);
    // Software reset request, then a power good loss while running.
    q[K_RST].push_back(2'h0);
    q[K_RST].push_back(2'h3);
    reset_req = 1'b1;
    tick(1);
    reset_req = 1'b0;
    tick(10);
    q[K_RST].push_back(2'h0);
    q[K_RST].push_back(2'h3);
    rails_on = 1'b0;
    tick(20);
    rails_on = 1'b1;
    tick(40);
    // Every sleep code; only the non-S3 codes may fall into deep sleep.
    deep_en = 1'b1;
    for (int k = 0; k < 4; k++) begin
      q[K_ST].push_back(2'h2);
      if (k != 0) q[K_ST].push_back(2'h1);
      q[K_RST].push_back(k == 0 ? 2'h1 : 2'h0);
      sleep_go(k[1:0]);
      tick(5 + int'(lfsr_q[2:0]));
      // After S3 the DRAM reset is released, so the wake's reset hold drives it again.
      if (k == 0) q[K_RST].push_back(2'h0);
      expect_wake();
      if (lfsr_q[3]) wake_req = 1'b1;
      else wake_pin = 1'b1;
      lfsr_q = lfsr(lfsr_q);
      tick(20);
      wake_req = 1'b0;
      wake_pin = 1'b0;
      tick(10);
    end
    // Battery low: interrupt only when enabled, wake refused, deep entry gated by mains.
    batt_only = 1'b1;
    batt_ok = 1'b0;
    tick(10);
    batt_ok = 1'b1;
    tick(10);
    smi_en = 1'b1;
    q[K_SMI].push_back(2'h0);
    q[K_SMI].push_back(2'h1);
    batt_ok = 1'b0;
    tick(10);
    smi_ack = 1'b1;
    tick(1);
    smi_ack = 1'b0;
    q[K_ST].push_back(2'h2);
    q[K_RST].push_back(2'h0);
    sleep_go(2'h1);
    wake_req = 1'b1;
    tick(20);
    q[K_ST].push_back(2'h1);
    on_mains = 1'b0;
    tick(20);
    expect_wake();
    batt_ok = 1'b1;
    tick(25);
    wake_req = 1'b0;
    tick(10);
    for (int k = 0; k < 5; k++) begin
      if (q[k].size() != 0) begin
        miscompares++;
        $display("[FAIL] %0t missing change of kind %0d", $time, k);
      end
    end
    give_verdict();
  end
endmodule // tb

`default_nettype wire
